// ---- design/hbs_boot_seq.sv ----
// Purpose: Boot stage sequencer, strap decoder and GPIO control of a USB hub.
// Assumes: All inputs synchronous to sys_clk; engines outside report done pulses.
// Notes: The chip reset low is standby; rst is the power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "hbs_defs.svh"

module hbs_boot_seq #(
  parameter int GPIO_CNT = 8,
  parameter int CFG_W = 16
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chipResetN,
  // Straps
  input wire logic [2:0] fixedPortStrap,
  input wire logic [2:0] chargePortStrap,
  input wire logic [2:0] roleStrap,
  input wire logic spiModeStrap,
  input wire logic clkValid,
  // External ROM probe engine
  output logic romProbeStart,
  output logic [15:0] romProbeAddr,
  input wire logic romProbeDone,
  input wire logic romSigValid,
  output logic extExec,
  output logic [15:0] extExecAddr,
  // Serial pin pull-up sense
  input wire logic mgmtSerialDatPullUp,
  input wire logic mgmtSerialClkPullUp,
  // Host register write port (serial slave)
  input wire logic hostWrEn,
  input wire logic [7:0] hostWrAddr,
  input wire logic [CFG_W-1:0] hostWrData,
  // Configuration sources
  input wire logic [CFG_W-1:0] romDefaults,
  input wire logic [CFG_W-1:0] strapOverride,
  input wire logic [CFG_W-1:0] strapOverrideMask,
  input wire logic [CFG_W-1:0] otpData,
  input wire logic [CFG_W-1:0] otpMask,
  // Bus presence
  input wire logic vbus,
  input wire logic connectReq,
  input wire logic chargerDetectDone,
  input wire logic enumerated,
  // GPIO write ports
  input wire logic gpioSerWr,
  input wire logic gpioUsbWr,
  input wire logic [GPIO_CNT-1:0] gpioSel,
  input wire logic [3:0] gpioCfg,
  // GPIO pins
  input wire logic [GPIO_CNT-1:0] gpioIn,
  output logic [GPIO_CNT-1:0] gpioOut,
  output logic [GPIO_CNT-1:0] gpioOe,
  output logic [GPIO_CNT-1:0] gpioPullUp,
  output logic [GPIO_CNT-1:0] gpioPullDown,
  output logic [GPIO_CNT-1:0] gpioLevel,
  // Status
  output hbs_pkg::hbs_stage_e stage,
  output logic pllRun,
  output logic portsEnabled,
  output logic usbConnect,
  output logic slaveCfgSetting,
  output logic bridgeMasterSetting,
  output logic [`HBS_PORT_CNT-1:0] fixedPorts,
  output logic [`HBS_PORT_CNT-1:0] chargePorts,
  output logic fixedPortReserved,
  output logic [CFG_W-1:0] activeCfg
);

  if (GPIO_CNT < 1 || GPIO_CNT > 32 || CFG_W < 1) begin : g_param_check
    $error("GPIO_CNT or CFG_W out of range");
  end

  // Thermometer decode shared by both port straps.
  function automatic logic [`HBS_PORT_CNT-1:0] thermo(input logic [2:0] n);
    logic [`HBS_PORT_CNT-1:0] m;
    m = '0;
    for (int i = 0; i < `HBS_PORT_CNT; i++) begin
      if (i < int'(n)) m[i] = 1'b1;
    end
    return m;
  endfunction : thermo

  hbs_pkg::hbs_stage_e next_stage;
  logic [2:0] fixedIdx;
  logic [2:0] chargeIdx;
  logic [2:0] roleIdx;
  logic spiSel;
  logic strapsHeld;
  logic [CFG_W-1:0] socCfg;
  logic [CFG_W-1:0] socMask;
  logic [CFG_W-1:0] baseCfg;
  logic cfgDoneWr;
  logic standbyNow;

  assign standbyNow = !chipResetN;
  assign cfgDoneWr = hostWrEn && (hostWrAddr == `HBS_CFG_DONE_ADDR);

  // Straps are caught on the first clock after chip reset lets go, so the
  // pins only need to be settled by then and later changes are ignored.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapsHeld <= 1'b0;
      fixedIdx <= 3'h0;
      chargeIdx <= 3'h0;
      roleIdx <= 3'h0;
      spiSel <= 1'b0;
    end else if (standbyNow) begin
      strapsHeld <= 1'b0;
    end else if (!strapsHeld) begin
      strapsHeld <= 1'b1;
      fixedIdx <= fixedPortStrap;
      chargeIdx <= chargePortStrap;
      roleIdx <= roleStrap;
      spiSel <= spiModeStrap;
    end
  end

  always_comb begin
    next_stage = stage;
    unique case (stage)
      hbs_pkg::ST_STANDBY:
        if (strapsHeld && clkValid) next_stage = hbs_pkg::ST_ROM_PROBE;
      hbs_pkg::ST_ROM_PROBE:
        if (!spiSel) next_stage = hbs_pkg::ST_DEFAULT_LOAD;
        else if (romProbeDone) begin
          next_stage = romSigValid ? hbs_pkg::ST_STRAP_SAMPLE
                                   : hbs_pkg::ST_DEFAULT_LOAD;
        end
      hbs_pkg::ST_DEFAULT_LOAD: next_stage = hbs_pkg::ST_STRAP_SAMPLE;
      hbs_pkg::ST_STRAP_SAMPLE:
        if (roleIdx == `HBS_STRAP_SLAVE && mgmtSerialDatPullUp && mgmtSerialClkPullUp) begin
          next_stage = hbs_pkg::ST_HOST_CFG;
        end else begin
          next_stage = hbs_pkg::ST_MERGE;
        end
      hbs_pkg::ST_HOST_CFG:
        if (cfgDoneWr) next_stage = hbs_pkg::ST_MERGE;
      hbs_pkg::ST_MERGE: next_stage = hbs_pkg::ST_IDLE;
      hbs_pkg::ST_IDLE:
        if (vbus) next_stage = (chargeIdx != `HBS_CHARGE_NONE) ? hbs_pkg::ST_CHARGER_DETECT
                                                    : hbs_pkg::ST_CONNECT;
        else if (!connectReq) next_stage = hbs_pkg::ST_SUSPEND;
      hbs_pkg::ST_SUSPEND:
        if (vbus) next_stage = (chargeIdx != `HBS_CHARGE_NONE) ? hbs_pkg::ST_CHARGER_DETECT
                                                    : hbs_pkg::ST_CONNECT;
        else if (connectReq) next_stage = hbs_pkg::ST_IDLE;
      hbs_pkg::ST_CHARGER_DETECT:
        if (chargerDetectDone) next_stage = hbs_pkg::ST_CONNECT;
      hbs_pkg::ST_CONNECT:
        if (!vbus) next_stage = hbs_pkg::ST_IDLE;
        else if (enumerated) next_stage = hbs_pkg::ST_NORMAL;
      hbs_pkg::ST_NORMAL:
        if (!vbus) next_stage = hbs_pkg::ST_IDLE;
      default: next_stage = hbs_pkg::ST_STANDBY;
    endcase
    if (standbyNow) next_stage = hbs_pkg::ST_STANDBY;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) stage <= hbs_pkg::ST_STANDBY;
    else stage <= next_stage;
  end

  // Probe request and external execution pointer.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      romProbeStart <= 1'b0;
      romProbeAddr <= `HBS_ROM_SIG_ADDR;
      extExec <= 1'b0;
      extExecAddr <= `HBS_ROM_EXEC_ADDR;
    end else begin
      romProbeStart <= (next_stage == hbs_pkg::ST_ROM_PROBE) && spiSel
                       && (stage != hbs_pkg::ST_ROM_PROBE);
      romProbeAddr <= `HBS_ROM_SIG_ADDR;
      extExecAddr <= `HBS_ROM_EXEC_ADDR;
      if (standbyNow) extExec <= 1'b0;
      else if (stage == hbs_pkg::ST_ROM_PROBE && spiSel && romProbeDone) begin
        extExec <= romSigValid;
      end
    end
  end

  // Configuration build: defaults, strap overrides, SOC writes, OTP.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      baseCfg <= '0;
      socCfg <= '0;
      socMask <= '0;
      activeCfg <= '0;
    end else if (standbyNow) begin
      baseCfg <= '0;
      socCfg <= '0;
      socMask <= '0;
      activeCfg <= '0;
    end else begin
      if (stage == hbs_pkg::ST_ROM_PROBE) baseCfg <= romDefaults;
      if (stage == hbs_pkg::ST_DEFAULT_LOAD) begin
        baseCfg <= (romDefaults & ~strapOverrideMask)
                   | (strapOverride & strapOverrideMask);
      end
      if (stage == hbs_pkg::ST_HOST_CFG && hostWrEn && !cfgDoneWr) begin
        socCfg <= hostWrData;
        socMask <= socMask | hostWrData;
      end
      if (stage == hbs_pkg::ST_MERGE) begin
        activeCfg <= (((baseCfg & ~socMask) | (socCfg & socMask)) & ~otpMask)
                     | (otpData & otpMask);
      end
    end
  end

  // Stage side effects and strap decode.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pllRun <= 1'b0;
      portsEnabled <= 1'b0;
      usbConnect <= 1'b0;
      slaveCfgSetting <= 1'b0;
      bridgeMasterSetting <= 1'b0;
      fixedPorts <= '0;
      chargePorts <= '0;
      fixedPortReserved <= 1'b0;
    end else begin
      pllRun <= !standbyNow && clkValid;
      portsEnabled <= !standbyNow && (stage == hbs_pkg::ST_CONNECT
                      || stage == hbs_pkg::ST_NORMAL);
      usbConnect <= !standbyNow && vbus && (stage == hbs_pkg::ST_CONNECT
                    || stage == hbs_pkg::ST_NORMAL);
      slaveCfgSetting <= strapsHeld && roleIdx == `HBS_STRAP_SLAVE;
      bridgeMasterSetting <= strapsHeld && roleIdx == `HBS_STRAP_MASTER;
      fixedPortReserved <= strapsHeld && fixedIdx == `HBS_FIXED_RESERVED;
      // Fixed ports start at port 3; index 5 is reserved and fixes nothing.
      fixedPorts <= (!strapsHeld || fixedIdx >= `HBS_FIXED_RESERVED) ? '0
                    : (thermo(fixedIdx) << `HBS_FIXED_SHIFT);
      chargePorts <= !strapsHeld ? '0 : (chargeIdx >= `HBS_CHARGE_ALL) ? '1
                     : thermo(chargeIdx);
    end
  end

  // GPIO cfg word: bit0 output, bit1 high level, bit2 pull-up, bit3 pull-down.
  genvar g;
  generate
    for (g = 0; g < GPIO_CNT; g++) begin : gpio_bit
      logic wr;
      assign wr = enumerated && (gpioSerWr || gpioUsbWr) && gpioSel[g];
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          gpioOe[g] <= 1'b0;
          gpioOut[g] <= 1'b0;
          gpioPullUp[g] <= 1'b0;
          gpioPullDown[g] <= 1'b0;
          gpioLevel[g] <= 1'b0;
        end else begin
          gpioLevel[g] <= gpioIn[g];
          if (standbyNow) begin
            gpioOe[g] <= 1'b0;
            gpioOut[g] <= 1'b0;
            gpioPullUp[g] <= 1'b0;
            gpioPullDown[g] <= 1'b0;
          end else if (wr) begin
            gpioOe[g] <= gpioCfg[0];
            gpioOut[g] <= gpioCfg[0] & gpioCfg[1];
            gpioPullUp[g] <= !gpioCfg[0] & gpioCfg[2];
            gpioPullDown[g] <= !gpioCfg[0] & !gpioCfg[2] & gpioCfg[3];
          end
        end
      end
    end
  endgenerate

  AST_STANDBY_ON_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    !chipResetN |=> stage == hbs_pkg::ST_STANDBY)
    else $error("stage not standby while chip reset low");
  AST_HOST_CFG_EXIT: assert property (@(posedge sys_clk) disable iff (rst)
    (stage == hbs_pkg::ST_HOST_CFG && chipResetN && cfgDoneWr)
    |=> stage == hbs_pkg::ST_MERGE)
    else $error("host config did not end on done write");
  AST_HOST_CFG_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (stage == hbs_pkg::ST_HOST_CFG && chipResetN && !cfgDoneWr)
    |=> stage == hbs_pkg::ST_HOST_CFG)
    else $error("host config left without done write");
  AST_SLAVE_PROBE: assert property (@(posedge sys_clk) disable iff (rst)
    (stage == hbs_pkg::ST_STRAP_SAMPLE && chipResetN)
    |=> stage == ((roleIdx == `HBS_STRAP_SLAVE && $past(mgmtSerialDatPullUp)
    && $past(mgmtSerialClkPullUp)) ? hbs_pkg::ST_HOST_CFG : hbs_pkg::ST_MERGE))
    else $error("wrong stage after strap sample");
  AST_VBUS_ROUTE: assert property (@(posedge sys_clk) disable iff (rst)
    ((stage == hbs_pkg::ST_IDLE || stage == hbs_pkg::ST_SUSPEND) && chipResetN && vbus)
    |=> stage == ((chargeIdx != `HBS_CHARGE_NONE) ? hbs_pkg::ST_CHARGER_DETECT
    : hbs_pkg::ST_CONNECT))
    else $error("wrong stage after vbus");
  AST_CONNECT_STAY: assert property (@(posedge sys_clk) disable iff (rst)
    (stage == hbs_pkg::ST_CONNECT && chipResetN && vbus && !enumerated)
    |=> stage == hbs_pkg::ST_CONNECT && usbConnect)
    else $error("connect stage left with vbus high");
  AST_STRAP_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (strapsHeld && chipResetN) |=> $stable(fixedIdx) && $stable(chargeIdx))
    else $error("captured strap changed");
  AST_NO_SPI_SKIP: assert property (@(posedge sys_clk) disable iff (rst)
    (stage == hbs_pkg::ST_ROM_PROBE && !spiSel && chipResetN)
    |=> stage == hbs_pkg::ST_DEFAULT_LOAD)
    else $error("probe not skipped without spi strap");
  AST_SIG_VALID: assert property (@(posedge sys_clk) disable iff (rst)
    (stage == hbs_pkg::ST_ROM_PROBE && spiSel && romProbeDone && romSigValid && chipResetN)
    |=> extExec && stage == hbs_pkg::ST_STRAP_SAMPLE)
    else $error("valid signature not honoured");
  AST_CHARGE_ALL: assert property (@(posedge sys_clk) disable iff (rst)
    (strapsHeld && chargeIdx == `HBS_CHARGE_ALL) |=> chargePorts == '1)
    else $error("charge strap top option wrong");

endmodule : hbs_boot_seq
`default_nettype wire

// ---- design/hbs_defs.svh ----
// Purpose: Constants for the hub boot and strap sequencer.
// Assumes: Included by bare name from design files.
// Notes: Strap indices run 0 (lowest resistor option) to 5.
`ifndef HBS_DEFS_SVH
`define HBS_DEFS_SVH
`define HBS_CFG_DONE_ADDR 8'hff
`define HBS_ROM_SIG_ADDR 16'hfffa
`define HBS_ROM_EXEC_ADDR 16'h0000
`define HBS_STRAP_MASTER 3'h0
`define HBS_STRAP_SLAVE 3'h1
`define HBS_PORT_CNT 6
`define HBS_FIXED_RESERVED 3'h5
`define HBS_FIXED_SHIFT 3'h2
`define HBS_CHARGE_NONE 3'h0
`define HBS_CHARGE_ALL 3'h5
`endif

// ---- design/hbs_pkg.sv ----
// Purpose: Types for the hub boot and strap sequencer.
// Assumes: Used with package scope, never imported.
// Notes: Stage codes are one-hot.
package hbs_pkg;
  typedef enum logic [10:0] {
    ST_STANDBY = 11'h001,
    ST_ROM_PROBE = 11'h002,
    ST_DEFAULT_LOAD = 11'h004,
    ST_STRAP_SAMPLE = 11'h008,
    ST_HOST_CFG = 11'h010,
    ST_MERGE = 11'h020,
    ST_IDLE = 11'h040,
    ST_SUSPEND = 11'h080,
    ST_CHARGER_DETECT = 11'h100,
    ST_CONNECT = 11'h200,
    ST_NORMAL = 11'h400
  } hbs_stage_e;
endpackage : hbs_pkg

// ---- tb/hbs_rom_model.sv ----
// Purpose: Far-side model of the external ROM seen through the probe engine.
// Assumes: One probe per start pulse; the bench sets reply delay and content.
// Notes: Outside a reply the valid line shows the inverse of the reply value.
`timescale 1ns/1ps
`default_nettype none
module hbs_rom_model (
  // Clock
  input wire logic sys_clk,
  // Probe handshake
  input wire logic romProbeStart,
  input wire logic [15:0] romProbeAddr,
  output logic romProbeDone,
  output logic romSigValid,
  // Bench control
  input wire logic sigOk,
  input wire logic [3:0] replyDelay
);
  int cnt = -1;
  // A part of 1 Mbit at 60 MHz or more; only its signature is modelled.
  always @(posedge sys_clk) begin
    romProbeDone <= 1'b0;
    romSigValid <= ~sigOk;
    if (romProbeStart) begin
      cnt <= int'(replyDelay);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      cnt <= -1;
      romProbeDone <= 1'b1;
      romSigValid <= sigOk && (romProbeAddr == 16'hfffa);
    end
  end
endmodule : hbs_rom_model
`default_nettype wire

// ---- tb/hub_boot_strap_sequencer_tb_top.sv ----
// Purpose: Self-checking bench of the boot stage sequencer.
// Assumes: Inputs change 5 ns after the rising edge; stages are polled.
// Notes: Every wait is bounded so a stuck stage ends the run.
`timescale 1ns/1ps
`default_nettype none
module hub_boot_strap_sequencer_tb_top;
  logic sys_clk = 1'b0, rst = 1'b1, chipResetN = 1'b0, spiModeStrap = 1'b0, clkValid = 1'b1;
  logic [2:0] fixedPortStrap = 3'h0, chargePortStrap = 3'h0, roleStrap = 3'h0;
  logic romProbeStart, romProbeDone, romSigValid, extExec, sigOk = 1'b0, datPu = 1'b0;
  logic clkPu = 1'b0, hostWrEn = 1'b0, vbus = 1'b0, connectReq = 1'b0, detDone = 1'b0;
  logic enumerated = 1'b0, gpioSerWr = 1'b0, gpioUsbWr = 1'b0, sawLoad = 1'b0;
  logic [3:0] replyDelay = 4'h1, gpioCfg = 4'h0;
  logic [15:0] romProbeAddr, extExecAddr, hostWrData = 16'h0000, romDef = 16'h00f0;
  logic [15:0] strOv = 16'h0a00, strMask = 16'h0f00, otp = 16'h0003, otpMask = 16'h000f;
  logic [15:0] activeCfg;
  logic [7:0] hostWrAddr = 8'h00, gpioSel = 8'h00, gpioIn = 8'h00;
  logic [7:0] gpioOut, gpioOe, gpioPullUp, gpioPullDown, gpioLevel;
  logic pllRun, portsEnabled, usbConnect, slaveSet, masterSet, fixRes;
  logic [5:0] fixedPorts, chargePorts;
  logic [5:0] fixExp [6] = '{6'h00, 6'h04, 6'h0c, 6'h1c, 6'h3c, 6'h00};
  logic [5:0] chgExp [6] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h3f};
  hbs_pkg::hbs_stage_e stage;
  int miscompares = 0, checked = 0;

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (!chipResetN) sawLoad <= 1'b0;
    else if (stage === hbs_pkg::ST_DEFAULT_LOAD) sawLoad <= 1'b1;
  end

  hbs_boot_seq i_dut (.sys_clk(sys_clk), .rst(rst), .chipResetN(chipResetN),
    .fixedPortStrap(fixedPortStrap), .chargePortStrap(chargePortStrap), .roleStrap(roleStrap),
    .spiModeStrap(spiModeStrap), .clkValid(clkValid), .romProbeStart(romProbeStart),
    .romProbeAddr(romProbeAddr), .romProbeDone(romProbeDone), .romSigValid(romSigValid),
    .extExec(extExec), .extExecAddr(extExecAddr), .mgmtSerialDatPullUp(datPu),
    .mgmtSerialClkPullUp(clkPu), .hostWrEn(hostWrEn), .hostWrAddr(hostWrAddr),
    .hostWrData(hostWrData), .romDefaults(romDef), .strapOverride(strOv),
    .strapOverrideMask(strMask), .otpData(otp), .otpMask(otpMask), .vbus(vbus),
    .connectReq(connectReq), .chargerDetectDone(detDone), .enumerated(enumerated),
    .gpioSerWr(gpioSerWr), .gpioUsbWr(gpioUsbWr), .gpioSel(gpioSel), .gpioCfg(gpioCfg),
    .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioPullUp(gpioPullUp),
    .gpioPullDown(gpioPullDown), .gpioLevel(gpioLevel), .stage(stage), .pllRun(pllRun),
    .portsEnabled(portsEnabled), .usbConnect(usbConnect), .slaveCfgSetting(slaveSet),
    .bridgeMasterSetting(masterSet), .fixedPorts(fixedPorts), .chargePorts(chargePorts),
    .fixedPortReserved(fixRes), .activeCfg(activeCfg));
  hbs_rom_model i_rom (.sys_clk(sys_clk), .romProbeStart(romProbeStart),
    .romProbeAddr(romProbeAddr), .romProbeDone(romProbeDone), .romSigValid(romSigValid),
    .sigOk(sigOk), .replyDelay(replyDelay));

  task automatic step();
    @(posedge sys_clk);
    #5;
  endtask : step

  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic waitStage(input hbs_pkg::hbs_stage_e exp, input int limit);
    int n;
    for (n = 0; n < limit && stage !== exp; n++) step();
    check(32'(stage), 32'(exp), "stage");
    if (stage !== exp) complete_run();
  endtask : waitStage

  // The fixed and charge port strap inputs move after capture to show the captured copy is what counts.
  task automatic boot(input logic spi, input logic [2:0] role);
    spiModeStrap = spi;
    roleStrap = role;
    chipResetN = 1'b0;
    repeat (3) step();
    check({stage, pllRun, portsEnabled, usbConnect}, {hbs_pkg::ST_STANDBY, 3'h0}, "standby");
    chipResetN = 1'b1;
    waitStage(hbs_pkg::ST_ROM_PROBE, 4);
    check({pllRun, romProbeStart}, {1'b1, spi}, "pll and probe start");
    fixedPortStrap = fixedPortStrap ^ 3'h1;
    chargePortStrap = chargePortStrap ^ 3'h1;
  endtask : boot

  function automatic logic [15:0] mergeExp(input logic [15:0] soc);
    logic [15:0] v;
    v = (romDef & ~strMask) | (strOv & strMask) | soc;
    return (v & ~otpMask) | (otp & otpMask);
  endfunction : mergeExp

  task automatic scnStraps();
    for (int i = 0; i < 6; i++) begin
      fixedPortStrap = 3'(i);
      chargePortStrap = 3'(5 - i);
      romDef = 16'h00f0 ^ 16'(i << 12);
      boot(1'b0, 3'h0);
      waitStage(hbs_pkg::ST_DEFAULT_LOAD, 3);
      waitStage(hbs_pkg::ST_STRAP_SAMPLE, 3);
      waitStage(hbs_pkg::ST_MERGE, 3);
      waitStage(hbs_pkg::ST_IDLE, 3);
      check(activeCfg, mergeExp(16'h0000), "merged config");
      check({fixedPorts, fixRes}, {fixExp[i], i == 5}, "fixed ports");
      check(chargePorts, chgExp[5 - i], "charge ports");
      check({slaveSet, masterSet}, 2'b01, "role");
      waitStage(hbs_pkg::ST_SUSPEND, 4);
      vbus = 1'b1;
      waitStage(i == 5 ? hbs_pkg::ST_CONNECT : hbs_pkg::ST_CHARGER_DETECT, 4);
      detDone = 1'b1;
      step();
      detDone = 1'b0;
      waitStage(hbs_pkg::ST_CONNECT, 4);
      step();
      check({usbConnect, portsEnabled}, 2'b11, "connect");
      repeat (5) step();
      check(32'(stage), 32'(hbs_pkg::ST_CONNECT), "connect holds");
      vbus = 1'b0;
      waitStage(hbs_pkg::ST_IDLE, 4);
    end
  endtask : scnStraps

  task automatic scnSpi(input logic sig, input logic [3:0] dly);
    sigOk = sig;
    replyDelay = dly;
    boot(1'b1, 3'h0);
    check(romProbeAddr, 16'hfffa, "probe address");
    waitStage(sig ? hbs_pkg::ST_STRAP_SAMPLE : hbs_pkg::ST_DEFAULT_LOAD, 20);
    step();
    check({sawLoad, extExec}, {~sig, sig}, "external execution");
    if (sig) check(extExecAddr, 16'h0000, "execution address");
  endtask : scnSpi

  task automatic hostWr(input logic [7:0] a, input logic [15:0] d);
    hostWrEn = 1'b1;
    hostWrAddr = a;
    hostWrData = d;
    step();
    hostWrEn = 1'b0;
  endtask : hostWr

  task automatic scnHost(input logic [2:0] role, input logic pu);
    datPu = 1'b1;
    clkPu = pu;
    boot(1'b0, role);
    if (role == 3'h1 && pu) begin
      waitStage(hbs_pkg::ST_HOST_CFG, 8);
      repeat (30) step();
      hostWr(8'h10, 16'h8000);
      check(32'(stage), 32'(hbs_pkg::ST_HOST_CFG), "host config holds");
      step();
      hostWr(8'hff, 16'h0000);
      waitStage(hbs_pkg::ST_MERGE, 3);
    end else waitStage(hbs_pkg::ST_MERGE, 8);
    waitStage(hbs_pkg::ST_IDLE, 3);
    check(activeCfg, mergeExp((role == 3'h1 && pu) ? 16'h8000 : 16'h0000), "soc cfg");
    check({slaveSet, masterSet}, {role == 3'h1, 1'b0}, "role");
  endtask : scnHost

  task automatic gpioWr(input logic usb, input logic [7:0] sel, input logic [3:0] cfg);
    gpioSerWr = ~usb;
    gpioUsbWr = usb;
    gpioSel = sel;
    gpioCfg = cfg;
    step();
    {gpioSerWr, gpioUsbWr} = 2'b00;
    step();
  endtask : gpioWr

  task automatic scnGpio();
    gpioIn = 8'h5a;
    gpioWr(1'b0, 8'h04, 4'h1);
    enumerated = 1'b1;
    step();
    gpioWr(1'b0, 8'h01, 4'h3);
    gpioWr(1'b1, 8'h02, 4'h4);
    gpioWr(1'b1, 8'h08, 4'h8);
    step();
    check({gpioOe, gpioOut}, 16'h0101, "gpio drive");
    check({gpioPullUp, gpioPullDown}, 16'h0208, "gpio pulls");
    check(gpioLevel, 8'h5a, "gpio level");
    connectReq = 1'b1;
    waitStage(hbs_pkg::ST_IDLE, 3);
    repeat (2) step();
    check(32'(stage), 32'(hbs_pkg::ST_IDLE), "idle holds on connect");
    {vbus, connectReq, detDone} = 3'b101;
    waitStage(hbs_pkg::ST_NORMAL, 6);
    detDone = 1'b0;
    check({usbConnect, portsEnabled}, 2'b11, "normal");
    vbus = 1'b0;
    waitStage(hbs_pkg::ST_IDLE, 3);
  endtask : scnGpio

  initial begin
    repeat (6) step();
    rst = 1'b0;
    scnStraps();
    scnSpi(1'b1, 4'h6);
    scnSpi(1'b0, 4'h0);
    scnHost(3'h1, 1'b1);
    scnHost(3'h1, 1'b0);
    scnHost(3'h2, 1'b1);
    scnGpio();
    complete_run();
  end
endmodule : hub_boot_strap_sequencer_tb_top
`default_nettype wire
